// file: dv/gps_pad_model.sv
// Behavioural pads on the far side of the I/O port.
// Assumes the bench commands what the outside world drives per pin.
`timescale 1ns/1ps
`default_nettype none
module gps_pad_model
(
  input  wire logic       ref_clk,        // System clock
  input  wire logic [7:0] pad_out,        // Level driven by the port
  input  wire logic [7:0] pad_oe,         // Port drives the pin
  input  wire logic [7:0] pad_pull_up,    // Pull-up enabled
  input  wire logic [7:0] pad_pull_down,  // Pull-down enabled
  input  wire logic [7:0] ext_val,        // Level forced from outside
  input  wire logic [7:0] ext_en,         // Outside world drives the pin
  output var  logic [7:0] pad_in          // Resolved pin level
);
  logic [7:0] float_q = 8'h55;  // Wandering pattern for pins nobody holds

  // Undriven pins change every cycle so no stale level passes as valid
  always @(posedge ref_clk)
  begin
    float_q <= ~float_q;
  end

  // port drive first
  // The port wins, then outside drive, then the pulls, else floating
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (pad_oe[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else if (pad_pull_up[i])
        pad_in[i] = 1'b1;
      else if (pad_pull_down[i])
        pad_in[i] = 1'b0;
      else
        pad_in[i] = float_q[i];
    end
  end
endmodule
`default_nettype wire

// file: dv/test_gps_port_setup_and_map.sv
// Self-checking bench for the I/O port, instantiated as port C.
// Assumes a 10 MHz clock and the pad model as the far side.
`timescale 1ns/1ps
`default_nettype none
module test_gps_port_setup_and_map;
  localparam logic [31:0] BASE = 32'h4000_6000;  // Port C base
  logic ref_clk, arst_n, rd_en, wr_en;           // Clock, reset, strobes
  logic [31:0] addr, wdata, rdata;               // Bus fields
  logic [3:0]  ben;                              // Byte enables
  logic [1:0]  resp, last_resp;                  // Response codes
  logic        waitreq, irq;                     // Handshake, interrupt
  logic [7:0]  pad_in, pad_out, pad_oe, pu, pd;  // Pad side
  logic [7:0]  digital_enable_bit, dr8, slew, p_in, p_out, p_oe;
  logic [7:0]  ext_val, ext_en;                  // Outside drive commands
  logic [31:0] d;                                // Scratch read data
  int          error_cnt, total_checks;          // Report counters
  // Mode table {sense, both, polarity, from, to, expected raw}
  localparam logic [5:0] MODES [6] = '{6'h0b, 6'h0c, 6'h05, 6'h15,
                                       6'h2b, 6'h22};

  // Two unbonded pins (7:6) exercise the write-ignore path
  gps_port #(.PORT_ID(gps_pkg::GPS_PORT_C), .BONDED(8'h3f)) u_gps_port
  (
    .ref_clk(ref_clk), .arst_n(arst_n), .avs_address(addr),
    .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
    .avs_byteenable(ben), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .avs_response(resp), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pu),
    .pad_pull_down(pd), .pad_digital_en(digital_enable_bit), .pad_drive_8ma(dr8),
    .pad_slew(slew), .periph_in(p_in), .periph_out(p_out),
    .periph_oe(p_oe), .irq(irq)
  );

  gps_pad_model u_gps_pad_model
  (
    .ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_up(pu), .pad_pull_down(pd), .ext_val(ext_val),
    .ext_en(ext_en), .pad_in(pad_in)
  );

  // Free-running 100 ns clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Count and report one comparison of the low byte
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic [31:0] a, input logic w, logic [31:0] v);
    int n;
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    rd_en <= ~w;
    wr_en <= w;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (waitreq !== 1'b0 && n < 100);
    d = rdata;
    last_resp = resp;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    // A hung handshake ends the run as a mismatch
    if (n >= 100)
    begin
      error_cnt++;
      test_done();
    end
  endtask

  task automatic wr(input logic [11:0] o, input logic [7:0] v);
    bus(BASE + {20'h0, o}, 1'b1, {24'h0, v});
  endtask

  task automatic rd(input logic [11:0] o, input string nm, logic [7:0] e);
    bus(BASE + {20'h0, o}, 1'b0, 32'h0);
    chk(nm, e, d[7:0]);
  endtask

  // Single exit point with counts and verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    arst_n = 1'b0; rd_en = 1'b0; wr_en = 1'b0; addr = 32'h0;
    wdata = 32'h0; ben = 4'hf; p_out = 8'h00; p_oe = 8'h00;
    ext_val = 8'h00; ext_en = 8'hff; error_cnt = 0; total_checks = 0;
    repeat (16) @(posedge ref_clk);
    arst_n <= 1'b1;
    // three idle clocks after the gate opens before any access
    repeat (3) @(posedge ref_clk);
    chk("pad_oe reset", 8'h00, pad_oe);
    chk("pull_up pins", 8'h0f, pu);
    chk("pull_down pins", 8'h00, pd);
    rd(gps_pkg::OFS_ALT_FUNCTION_BIT, "alt reset", 8'h0f);
    rd(gps_pkg::OFS_PUR, "pull_up reset", 8'h0f);
    rd(gps_pkg::OFS_DEN, "dig_en reset", 8'h0f);
    rd(gps_pkg::OFS_PDR, "pull_down reset", 8'h00);
    rd(gps_pkg::OFS_COMMIT, "commit reset", 8'hf0);
    rd(gps_pkg::OFS_DIR, "dir reset", 8'h00);
    // Locked: protected bits keep debug selection, unbonded ignore
    wr(gps_pkg::OFS_ALT_FUNCTION_BIT, 8'hff);
    rd(gps_pkg::OFS_ALT_FUNCTION_BIT, "alt locked", 8'h3f);
    wr(gps_pkg::OFS_COMMIT, 8'h0f);
    rd(gps_pkg::OFS_COMMIT, "commit locked", 8'hf0);
    bus(BASE + 32'h520, 1'b1, gps_pkg::LOCK_KEY);
    rd(gps_pkg::OFS_LOCK, "lock open", 8'h00);
    wr(gps_pkg::OFS_COMMIT, 8'h00);
    rd(gps_pkg::OFS_COMMIT, "commit ro bits", 8'hf0);
    wr(gps_pkg::OFS_COMMIT, 8'h0f);
    rd(gps_pkg::OFS_COMMIT, "commit rw bits", 8'hff);
    wr(gps_pkg::OFS_ALT_FUNCTION_BIT, 8'h00);
    rd(gps_pkg::OFS_ALT_FUNCTION_BIT, "alt committed", 8'h00);
    // Every sense mode on pin 1 with a clean clear before the event
    for (int i = 0; i < 6; i++)
    begin
      ext_val[1] <= MODES[i][2];
      repeat (6) @(posedge ref_clk);
      wr(gps_pkg::OFS_SENSE, {6'h0, MODES[i][5], 1'b0});
      wr(gps_pkg::OFS_BOTH, {6'h0, MODES[i][4], 1'b0});
      wr(gps_pkg::OFS_POL, {6'h0, MODES[i][3], 1'b0});
      wr(gps_pkg::OFS_ICLR, 8'h02);
      ext_val[1] <= MODES[i][1];
      repeat (8) @(posedge ref_clk);
      bus(BASE + 32'h414, 1'b0, 32'h0);
      chk("raw mode", {7'h0, MODES[i][0]}, {7'h0, d[1]});
    end
    // Latch a rising edge, then mask and clear it
    wr(gps_pkg::OFS_SENSE, 8'h00);
    wr(gps_pkg::OFS_POL, 8'h02);
    ext_val[1] <= 1'b0;
    repeat (6) @(posedge ref_clk);
    wr(gps_pkg::OFS_ICLR, 8'h02);
    ext_val[1] <= 1'b1;
    repeat (8) @(posedge ref_clk);
    wr(gps_pkg::OFS_MASK, 8'h02);
    bus(BASE + 32'h418, 1'b0, 32'h0);
    chk("masked pass", 8'h02, d[7:0] & 8'h02);
    wr(gps_pkg::OFS_MASK, 8'h00);
    bus(BASE + 32'h418, 1'b0, 32'h0);
    chk("masked block", 8'h00, d[7:0] & 8'h02);
    wr(gps_pkg::OFS_ICLR, 8'h00);
    bus(BASE + 32'h414, 1'b0, 32'h0);
    chk("clear zero", 8'h02, d[7:0] & 8'h02);
    wr(gps_pkg::OFS_ICLR, 8'h02);
    bus(BASE + 32'h414, 1'b0, 32'h0);
    chk("clear one", 8'h00, d[7:0] & 8'h02);
    // Unmapped and foreign accesses, event status and interrupt line
    bus(BASE + 32'h600, 1'b0, 32'h0);
    bus(BASE + 32'h700, 1'b0, 32'h0);
    chk("bad resp", 8'h03, {6'h0, last_resp});
    repeat (3) @(posedge ref_clk);
    chk("irq masked", 8'h00, {7'h0, irq});
    rd(gps_pkg::OFS_EVSTAT, "event bad", 8'h02);
    wr(gps_pkg::OFS_EVMASK, 8'h02);
    bus(32'h4000_4000, 1'b1, 32'h0000_00ff);
    chk("other port", 8'h03, {6'h0, last_resp});
    repeat (3) @(posedge ref_clk);
    chk("irq raised", 8'h01, {7'h0, irq});
    rd(gps_pkg::OFS_EVSTAT, "event read", 8'h02);
    repeat (3) @(posedge ref_clk);
    chk("irq cleared", 8'h00, {7'h0, irq});
    rd(gps_pkg::OFS_DIR, "dir other port", 8'h00);
    // Outputs: unbonded ignore, masked data writes and reads
    ext_en <= 8'h00;
    wr(gps_pkg::OFS_DEN, 8'h3f);
    wr(gps_pkg::OFS_DIR, 8'hff);
    rd(gps_pkg::OFS_DIR, "dir bonded", 8'h3f);
    wr(12'h3fc, 8'h15);
    wr(12'h008, 8'hff);
    repeat (2) @(posedge ref_clk);
    chk("pad_oe out", 8'h3f, pad_oe & 8'h3f);
    chk("pad_out data", 8'h17, pad_out & 8'h3f);
    rd(12'h010, "masked read", 8'h04);
    wr(gps_pkg::OFS_ODR, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk("drain high", 8'h00, pad_oe & 8'h01);
    wr(12'h004, 8'h00);
    repeat (2) @(posedge ref_clk);
    chk("drain low", 8'h01, pad_oe & 8'h01);
    chk("drain level", 8'h00, pad_out & 8'h01);
    // Input capture through the synchroniser
    wr(gps_pkg::OFS_ODR, 8'h00);
    wr(gps_pkg::OFS_DIR, 8'h00);
    ext_val <= 8'h2a;
    ext_en <= 8'h3f;
    repeat (6) @(posedge ref_clk);
    bus(BASE + 32'h3fc, 1'b0, 32'h0);
    chk("captured", 8'h2a, d[7:0] & 8'h3f);
    // Peripheral takes pin 4 whatever the direction says
    ext_en <= 8'h2f;
    p_oe <= 8'h10;
    p_out <= 8'h10;
    wr(gps_pkg::OFS_DEN, 8'h3f);
    wr(gps_pkg::OFS_DR8, 8'h01);
    wr(gps_pkg::OFS_PDR, 8'h20);
    wr(gps_pkg::OFS_SLR, 8'h22);
    wr(gps_pkg::OFS_ALT_FUNCTION_BIT, 8'h10);
    repeat (6) @(posedge ref_clk);
    chk("alt oe", 8'h10, pad_oe & 8'h10);
    chk("alt out", 8'h10, pad_out & 8'h10);
    chk("periph in", 8'h10, p_in & 8'h10);
    chk("dig_en pins", 8'h3f, digital_enable_bit & 8'h3f);
    chk("drive pins", 8'h01, dr8 & 8'h3f);
    chk("pull_down set", 8'h20, pd & 8'h3f);
    chk("slew pins", 8'h22, slew & 8'h3f);
    test_done();
  end
endmodule
`default_nettype wire

// file: inc/gps_pkg.sv
// Package for the eight-bit general-purpose I/O port block.
// Assumes one 10 MHz clock domain and an Avalon-MM register slave.
package gps_pkg;

  // Pins per port instance
  localparam int unsigned PINS = 8;

  // Port identities selecting reset exceptions
  typedef enum logic [2:0]
  {
    GPS_PORT_A = 3'h0,
    GPS_PORT_B = 3'h1,
    GPS_PORT_C = 3'h2,
    GPS_PORT_D = 3'h3,
    GPS_PORT_E = 3'h4,
    GPS_PORT_F = 3'h5,
    GPS_PORT_G = 3'h6,
    GPS_PORT_H = 3'h7
  } gps_port_type;

  // Base addresses of each port in the system map
  localparam logic [31:0] BASE_LOW   = 32'h4000_4000;
  localparam logic [31:0] BASE_HIGH  = 32'h4002_4000;
  localparam logic [31:0] BASE_STEP  = 32'h0000_1000;

  // Register byte offsets within a port (12-bit window)
  localparam logic [11:0] OFS_DATA     = 12'h000;
  localparam logic [11:0] OFS_DIR      = 12'h400;
  localparam logic [11:0] OFS_SENSE    = 12'h404;
  localparam logic [11:0] OFS_BOTH     = 12'h408;
  localparam logic [11:0] OFS_POL      = 12'h40c;
  localparam logic [11:0] OFS_MASK     = 12'h410;
  localparam logic [11:0] OFS_RAW      = 12'h414;
  localparam logic [11:0] OFS_MSTAT    = 12'h418;
  localparam logic [11:0] OFS_ICLR     = 12'h41c;
  localparam logic [11:0] OFS_ALT_FUNCTION_BIT    = 12'h420;
  localparam logic [11:0] OFS_DR2      = 12'h500;
  localparam logic [11:0] OFS_DR4      = 12'h504;
  localparam logic [11:0] OFS_DR8      = 12'h508;
  localparam logic [11:0] OFS_ODR      = 12'h50c;
  localparam logic [11:0] OFS_PUR      = 12'h510;
  localparam logic [11:0] OFS_PDR      = 12'h514;
  localparam logic [11:0] OFS_SLR      = 12'h518;
  localparam logic [11:0] OFS_DEN      = 12'h51c;
  localparam logic [11:0] OFS_LOCK     = 12'h520;
  localparam logic [11:0] OFS_COMMIT   = 12'h524;
  localparam logic [11:0] OFS_EVSTAT   = 12'h600;
  localparam logic [11:0] OFS_EVMASK   = 12'h604;

  // Key that releases the port lock
  localparam logic [31:0] LOCK_KEY     = 32'h1acc_e551;

  // Reset values
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_DRIVE2    = 8'hff;
  localparam logic [7:0] RST_DBG_B     = 8'h80;
  localparam logic [7:0] RST_DBG_C     = 8'h0f;
  localparam logic [7:0] RST_CR_STD    = 8'hff;
  localparam logic [7:0] RST_CR_B      = 8'h7f;
  localparam logic [7:0] RST_CR_C      = 8'hf0;

  // Event status bit positions
  localparam int unsigned EV_PIN_IRQ   = 0;
  localparam int unsigned EV_BAD_ADDR  = 1;
  localparam int unsigned EV_LOCK_OPEN = 2;
  localparam int unsigned EV_BITS      = 3;

  // Wait-states before a bus answer
  localparam int unsigned WAIT_CYC     = 1;

endpackage

// file: verilog/gps_edge.sv
// Per-pin interrupt detector for the I/O port.
// Assumes pin samples are already synchronised to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module gps_edge
(
  input  wire logic ref_clk,        // System clock
  input  wire logic arst_n,         // Asynchronous reset
  input  wire logic pin_s,          // Synchronised pin level
  input  wire logic sense_level,    // 1 level, 0 edge
  input  wire logic both_edges,     // 1 both edges
  input  wire logic polarity,       // 1 high/rising, 0 low/falling
  input  wire logic clear,          // Clear latched edge
  output var  logic raw             // Raw interrupt condition
);

  logic prev_q;        // Previous pin sample
  logic latch_q;       // Latched edge event
  logic latch_d;       // Next latched edge
  wire  rise_w = pin_s & ~prev_q;
  wire  fall_w = ~pin_s & prev_q;

  wire  hit_w = both_edges ? (rise_w | fall_w)
              : (polarity ? rise_w : fall_w);
  wire  lvl_w = polarity ? pin_s : ~pin_s;

  // clear loses to a fresh edge
  assign latch_d = (hit_w & ~sense_level) | (latch_q & ~clear);

  // Edge history and latch
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prev_q  <= 1'b0;
      latch_q <= 1'b0;
    end
    else
    begin
      prev_q  <= pin_s;
      latch_q <= latch_d;
    end
  end

  // Level mode reports the pin directly
  assign raw = sense_level ? lvl_w : latch_q;

  // Two-sample views of the synchronised pin
  sequence s_rise_seen;
    !pin_s ##1 pin_s;
  endsequence

  sequence s_fall_seen;
    pin_s ##1 !pin_s;
  endsequence

  // a clear with a quiet pin empties the latch
  a_clear_edge: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (clear && !sense_level && !$rose(pin_s) && !$fell(pin_s)) |=> !raw)
    else $error("edge not cleared");

  // rising edge latches when polarity is high
  a_rise_latch: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (s_rise_seen ##0 (!sense_level && !both_edges && polarity))
    |=> (sense_level || raw))
    else $error("rising edge not latched");

  // falling edge latches when polarity is low
  a_fall_latch: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (s_fall_seen ##0 (!sense_level && !both_edges && !polarity))
    |=> (sense_level || raw))
    else $error("falling edge not latched");

  // both-edges mode latches a fall whatever the polarity
  a_both_latch: assert property (
    @(posedge ref_clk) disable iff (!arst_n)
    (s_fall_seen ##0 (!sense_level && both_edges))
    |=> (sense_level || raw))
    else $error("edge missed in both-edges mode");

endmodule
`default_nettype wire

// file: verilog/gps_port.sv
// Eight-bit general-purpose I/O port with Avalon-MM register slave.
// Assumes pads and peripherals are outside; pin inputs are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module gps_port
#(
  parameter gps_pkg::gps_port_type PORT_ID = gps_pkg::GPS_PORT_A,
  parameter logic [7:0] BONDED = 8'hff  // Pads present
)
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  output var  logic [1:0]  avs_response,
  input  wire logic [7:0]  pad_in,
  output var  logic [7:0]  pad_out,
  output var  logic [7:0]  pad_oe,
  output var  logic [7:0]  pad_pull_up,
  output var  logic [7:0]  pad_pull_down,
  output var  logic [7:0]  pad_digital_en,
  output var  logic [7:0]  pad_drive_8ma,
  output var  logic [7:0]  pad_slew,
  output var  logic [7:0]  periph_in,
  input  wire logic [7:0]  periph_out,
  input  wire logic [7:0]  periph_oe,
  output var  logic        irq
);

  // Reset images by port identity
  // debug pins default to debug function
  localparam logic [7:0] RST_DBG =
    (PORT_ID == gps_pkg::GPS_PORT_B) ? gps_pkg::RST_DBG_B :
    (PORT_ID == gps_pkg::GPS_PORT_C) ? gps_pkg::RST_DBG_C : gps_pkg::RST_ZERO;
  localparam logic [7:0] RST_CR =
    (PORT_ID == gps_pkg::GPS_PORT_B) ? gps_pkg::RST_CR_B :
    (PORT_ID == gps_pkg::GPS_PORT_C) ? gps_pkg::RST_CR_C : gps_pkg::RST_CR_STD;
  localparam logic [7:0] PROT = RST_DBG;  // Protected pins
  localparam logic [31:0] BASE =
    ((PORT_ID < gps_pkg::GPS_PORT_E) ? gps_pkg::BASE_LOW : gps_pkg::BASE_HIGH)
    + gps_pkg::BASE_STEP * 32'(PORT_ID[1:0]);

  // Bus handshake states
  typedef enum logic [1:0]
  {
    GPS_IDLE = 2'b00,
    GPS_WAIT = 2'b01,
    GPS_ANS  = 2'b11
  } gps_bus_type;

  gps_bus_type st_q;                // Bus state
  logic [7:0]  data_q, dir_q, is_q, ibe_q, iev_q, im_q;
  logic [7:0]  af_q, odr_q, pu_q, pd_q, den_q, slr_q, cr_q;
  logic [7:0]  dr2_q, dr4_q, dr8_q;
  logic        unlock_q;            // Port lock released
  logic [2:0]  evs_q, evm_q;        // Event status and mask
  logic [7:0]  pin_m_q, pin_s_q;    // Two-stage pin synchroniser
  logic [7:0]  raw_w;               // Per-pin raw interrupt
  logic [7:0]  iclr_w;              // Interrupt clear strobes
  logic [31:0] rdata_d;             // Next read data

  wire        hit_w  = (avs_address[31:12] == BASE[31:12]);
  wire [11:0] ofs_w  = {avs_address[11:2], 2'b00};
  wire        req_w  = (avs_read | avs_write) & (st_q == GPS_ANS);
  wire        wr_w   = avs_write & req_w & hit_w & avs_byteenable[0];
  wire        rd_w   = avs_read & req_w;
  wire [7:0]  wd_w   = avs_writedata[7:0];
  wire [7:0]  wmask_w = BONDED;
  wire        data_w  = (ofs_w[11:10] == 2'b00);
  wire        known_w = data_w || (ofs_w >= gps_pkg::OFS_DIR &&
                        ofs_w <= gps_pkg::OFS_ALT_FUNCTION_BIT) ||
                        (ofs_w >= gps_pkg::OFS_DR2 &&
                        ofs_w <= gps_pkg::OFS_COMMIT) ||
                        ofs_w == gps_pkg::OFS_EVSTAT ||
                        ofs_w == gps_pkg::OFS_EVMASK;
  wire        bad_w   = req_w & (~hit_w | ~known_w);
  wire [7:0]  amask_w = avs_address[9:2];    // Data address mask
  wire [7:0]  mis_w   = raw_w & im_q;
  // protected select needs unlock and commit
  wire [7:0]  afw_w   = wmask_w & (~PROT | (cr_q & {8{unlock_q}}));
  wire        lock_wr = wr_w & (ofs_w == gps_pkg::OFS_LOCK);
  wire [2:0]  ev_w;

  // Helper for masked register update
  function automatic logic [7:0] upd(input logic [7:0] old, nv, m);
    upd = (old & ~m) | (nv & m);
  endfunction

  assign iclr_w = (wr_w && ofs_w == gps_pkg::OFS_ICLR) ? wd_w : 8'h00;

  genvar g;
  generate
    for (g = 0; g < gps_pkg::PINS; g++)
    begin : g_pin
      gps_edge u_edge
      (
        .ref_clk     (ref_clk),
        .arst_n      (arst_n),
        .pin_s       (pin_s_q[g]),
        .sense_level (is_q[g]),
        .both_edges  (ibe_q[g]),
        .polarity    (iev_q[g]),
        .clear       (iclr_w[g]),
        .raw         (raw_w[g])
      );
    end
  endgenerate

  // Events: pin interrupt, bad access, unlock
  assign ev_w = {lock_wr & (avs_writedata == gps_pkg::LOCK_KEY),
                 bad_w, |mis_w};

  // Read mux
  always_comb
  begin
    rdata_d = 32'h0;
    unique case (1'b1)
      data_w:                            rdata_d[7:0] = data_q & amask_w;
      ofs_w == gps_pkg::OFS_DIR:         rdata_d[7:0] = dir_q;
      ofs_w == gps_pkg::OFS_SENSE:       rdata_d[7:0] = is_q;
      ofs_w == gps_pkg::OFS_BOTH:        rdata_d[7:0] = ibe_q;
      ofs_w == gps_pkg::OFS_POL:         rdata_d[7:0] = iev_q;
      ofs_w == gps_pkg::OFS_MASK:        rdata_d[7:0] = im_q;
      ofs_w == gps_pkg::OFS_RAW:         rdata_d[7:0] = raw_w;
      ofs_w == gps_pkg::OFS_MSTAT:       rdata_d[7:0] = mis_w;
      ofs_w == gps_pkg::OFS_ALT_FUNCTION_BIT:       rdata_d[7:0] = af_q;
      ofs_w == gps_pkg::OFS_DR2:         rdata_d[7:0] = dr2_q;
      ofs_w == gps_pkg::OFS_DR4:         rdata_d[7:0] = dr4_q;
      ofs_w == gps_pkg::OFS_DR8:         rdata_d[7:0] = dr8_q;
      ofs_w == gps_pkg::OFS_ODR:         rdata_d[7:0] = odr_q;
      ofs_w == gps_pkg::OFS_PUR:         rdata_d[7:0] = pu_q;
      ofs_w == gps_pkg::OFS_PDR:         rdata_d[7:0] = pd_q;
      ofs_w == gps_pkg::OFS_SLR:         rdata_d[7:0] = slr_q;
      ofs_w == gps_pkg::OFS_DEN:         rdata_d[7:0] = den_q;
      ofs_w == gps_pkg::OFS_LOCK:        rdata_d[0]   = ~unlock_q;
      ofs_w == gps_pkg::OFS_COMMIT:      rdata_d[7:0] = cr_q;
      ofs_w == gps_pkg::OFS_EVSTAT:      rdata_d[2:0] = evs_q;
      ofs_w == gps_pkg::OFS_EVMASK:      rdata_d[2:0] = evm_q;
      default:                           rdata_d = 32'h0;
    endcase
  end

  // Bus handshake: waitrequest held for two cycles (idle, wait), then answer
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q            <= GPS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      avs_response    <= 2'b00;
    end
    else
    begin
      unique case (st_q)
        GPS_IDLE: st_q <= (avs_read | avs_write) ? GPS_WAIT : GPS_IDLE;
        GPS_WAIT: st_q <= GPS_ANS;
        GPS_ANS:  st_q <= GPS_IDLE;
      endcase
      avs_waitrequest <= ~(st_q == GPS_WAIT);
      avs_readdata    <= (st_q == GPS_WAIT && avs_read && hit_w) ?
                         rdata_d : 32'h0;
      avs_response    <= (st_q == GPS_WAIT && (~hit_w | ~known_w)) ?
                         2'b11 : 2'b00;
    end
  end

  // Pin synchroniser: first stage feeds only the second
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_m_q <= 8'h00;
      pin_s_q <= 8'h00;
    end
    else
    begin
      pin_m_q <= pad_in;
      pin_s_q <= pin_m_q;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dir_q <= gps_pkg::RST_ZERO; odr_q <= gps_pkg::RST_ZERO;
      pd_q  <= gps_pkg::RST_ZERO; slr_q <= gps_pkg::RST_ZERO;
      is_q  <= gps_pkg::RST_ZERO; ibe_q <= gps_pkg::RST_ZERO;
      iev_q <= gps_pkg::RST_ZERO; im_q  <= gps_pkg::RST_ZERO;
      dr4_q <= gps_pkg::RST_ZERO; dr8_q <= gps_pkg::RST_ZERO;
      dr2_q <= gps_pkg::RST_DRIVE2;
      // debug pins start in debug function
      af_q  <= RST_DBG; pu_q <= RST_DBG; den_q <= RST_DBG;
      cr_q  <= RST_CR;
      unlock_q <= 1'b0;
      evm_q <= 3'h0;
    end
    else
    begin
      if (wr_w)
      begin
        unique case (1'b1)
          ofs_w == gps_pkg::OFS_DIR:    dir_q <= upd(dir_q, wd_w, wmask_w);
          ofs_w == gps_pkg::OFS_SENSE:  is_q  <= upd(is_q, wd_w, wmask_w);
          ofs_w == gps_pkg::OFS_BOTH:   ibe_q <= upd(ibe_q, wd_w, wmask_w);
          ofs_w == gps_pkg::OFS_POL:    iev_q <= upd(iev_q, wd_w, wmask_w);
          ofs_w == gps_pkg::OFS_MASK:   im_q  <= upd(im_q, wd_w, wmask_w);
          ofs_w == gps_pkg::OFS_ALT_FUNCTION_BIT:  af_q  <= upd(af_q, wd_w, afw_w);
          // Drive strengths are mutually exclusive per pin
          ofs_w == gps_pkg::OFS_DR2:
          begin
            dr2_q <= upd(dr2_q, wd_w, wmask_w);
            dr4_q <= dr4_q & ~(wd_w & wmask_w);
            dr8_q <= dr8_q & ~(wd_w & wmask_w);
          end
          ofs_w == gps_pkg::OFS_DR4:
          begin
            dr4_q <= upd(dr4_q, wd_w, wmask_w);
            dr2_q <= dr2_q & ~(wd_w & wmask_w);
            dr8_q <= dr8_q & ~(wd_w & wmask_w);
          end
          ofs_w == gps_pkg::OFS_DR8:
          begin
            dr8_q <= upd(dr8_q, wd_w, wmask_w);
            dr2_q <= dr2_q & ~(wd_w & wmask_w);
            dr4_q <= dr4_q & ~(wd_w & wmask_w);
          end
          ofs_w == gps_pkg::OFS_ODR:    odr_q <= upd(odr_q, wd_w, wmask_w);
          ofs_w == gps_pkg::OFS_PUR:    pu_q  <= upd(pu_q, wd_w, wmask_w);
          ofs_w == gps_pkg::OFS_PDR:    pd_q  <= upd(pd_q, wd_w, wmask_w);
          ofs_w == gps_pkg::OFS_SLR:    slr_q <= upd(slr_q, wd_w, wmask_w);
          ofs_w == gps_pkg::OFS_DEN:    den_q <= upd(den_q, wd_w, wmask_w);
          ofs_w == gps_pkg::OFS_COMMIT:
            cr_q <= upd(cr_q, wd_w, wmask_w & PROT & {8{unlock_q}});
          ofs_w == gps_pkg::OFS_LOCK:
            unlock_q <= (avs_writedata == gps_pkg::LOCK_KEY);
          ofs_w == gps_pkg::OFS_EVMASK: evm_q <= wd_w[2:0];
          default:                      evm_q <= evm_q;
        endcase
      end
    end
  end

  // Data register: capture inputs, masked writes to outputs
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      data_q <= gps_pkg::RST_ZERO;
    else
    begin
      data_q <= (data_q & dir_q) | (pin_s_q & ~dir_q);
      if (wr_w && data_w)
        data_q <= upd(data_q, wd_w, amask_w & dir_q & wmask_w);
    end
  end

  // Event status: set wins, read clears
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      evs_q <= 3'h0;
    else
      evs_q <= ev_w |
        ((rd_w && hit_w && ofs_w == gps_pkg::OFS_EVSTAT) ? 3'h0 : evs_q);
  end

  // Pad and interrupt outputs, all registered
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pad_out <= 8'h00; pad_oe <= 8'h00; pad_pull_up <= 8'h00;
      pad_pull_down <= 8'h00; pad_digital_en <= 8'h00;
      pad_drive_8ma <= 8'h00; pad_slew <= 8'h00; periph_in <= 8'h00;
      irq <= 1'b0;
    end
    else
    begin
      // pad mode: peripheral owns select, drain forces zero-only
      pad_out <= ~odr_q & ((af_q & periph_out) | (~af_q & data_q));
      pad_oe  <= den_q & BONDED &
                 ((af_q & periph_oe) | (~af_q & dir_q)) &
                 ~(odr_q & ((af_q & periph_out) | (~af_q & data_q)));
      pad_pull_up    <= pu_q;
      pad_pull_down  <= pd_q;
      pad_digital_en <= den_q;
      pad_drive_8ma  <= dr8_q;
      pad_slew       <= slr_q;
      periph_in      <= pin_s_q & den_q & af_q;
      irq            <= |(evs_q & evm_q);
    end
  end

  // no pin drives right after reset, debug pins included
  a_reset_undriven: assert property (@(posedge ref_clk)
    $rose(arst_n) |-> pad_oe == 8'h00)
    else $error("pad driven after reset");

  // commit bits of ordinary pins never move
  a_commit_readonly: assert property (
    @(posedge ref_clk) disable iff (!arst_n) $stable(cr_q & ~PROT))
    else $error("read-only commit bit changed");

endmodule
`default_nettype wire
